// >>> wdt_cfg.svh
// offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define WDT_OFF_CTRL 8'h00
`define WDT_OFF_STATUS 8'h04
`define WDT_OFF_MASK 8'h08
`define WDT_ADDR_MASK 8'hFC

// ----------------------------------------------------------------------------
// watchdog_control fields
// ----------------------------------------------------------------------------
`define WDT_B_RESTART 0
`define WDT_B_RST_EN 1
`define WDT_B_RST_OCC 2
`define WDT_B_TO_FLAG 3
`define WDT_B_SEL_LO 4
`define WDT_B_SEL_HI 5
`define WDT_B_IRQ_EN 6
`define WDT_B_POR 7

// ----------------------------------------------------------------------------
// status and mask fields
// ----------------------------------------------------------------------------
`define WDT_ST_TIMEOUT 0
`define WDT_ST_WDRESET 1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define WDT_RST_SEL 2'h0
`define WDT_RST_STATUS 2'h0
`define WDT_RST_MASK 2'h0

// ----------------------------------------------------------------------------
// timing: divider of 4 clocks, reset countdown of 512 ticks
// ----------------------------------------------------------------------------
`define WDT_DIV_LAST 8'h03
`define WDT_CD_LAST 9'h1FF
`define WDT_TIMEOUT0 32'h0000_1000
`define WDT_TIMEOUT1 32'h0000_8000
`define WDT_TIMEOUT2 32'h0004_0000
`define WDT_TIMEOUT3 32'h0020_0000

// ----------------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------------
`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// >>> wdt_pkg.sv
// types shared by the watchdog modules
package wdt_pkg;

  typedef enum logic [2:0] {
    CNT_OFF = 3'h1,
    CNT_RUN = 3'h2,
    CNT_CD  = 3'h4
  } cnt_state_e;

  typedef logic [31:0] word_t;

endpackage

// >>> wdt_if.sv
// signals between the watchdog control logic and its counter
`timescale 1ns/1ps
interface wdt_if;
  logic tick;
  logic clear;
  logic run;
  logic [31:0] limit;
  logic cd_arm;
  logic timeout;
  logic cd_active;
  logic cd_done;

  modport ctrl (
    output tick, clear, run, limit, cd_arm,
    input timeout, cd_active, cd_done
  );
  modport cnt (
    input tick, clear, run, limit, cd_arm,
    output timeout, cd_active, cd_done
  );
endinterface

// >>> wdt_counter.sv
// watchdog interval counter and reset countdown
`timescale 1ns/1ps
`include "wdt_cfg.svh"
module wdt_counter import wdt_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  wdt_if.cnt wif
);

  cnt_state_e state_r, state_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [8:0] cd_r, cd_nxt;
  logic to_r, to_nxt;
  logic done_r, done_nxt;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cd_nxt = cd_r;
    to_nxt = 1'b0;
    done_nxt = 1'b0;
    unique case (state_r)
      CNT_OFF: begin
        cnt_nxt = 32'h0;
        cd_nxt = 9'h0;
        if (wif.run) begin
          state_nxt = CNT_RUN;
        end
      end
      CNT_RUN: begin
        if (!wif.run) begin
          state_nxt = CNT_OFF;
        end else if (wif.clear) begin
          cnt_nxt = 32'h0;
        end else if (wif.cd_arm) begin
          state_nxt = CNT_CD;
          cd_nxt = 9'h0;
        end else if (wif.tick) begin
          if (cnt_r >= wif.limit - 32'h1) begin
            cnt_nxt = 32'h0;
            to_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 32'h1;
          end
        end
      end
      CNT_CD: begin
        if (wif.clear || !wif.cd_arm) begin
          state_nxt = wif.run ? CNT_RUN : CNT_OFF;
          cnt_nxt = 32'h0;
          cd_nxt = 9'h0;
        end else if (wif.tick) begin
          if (cd_r == `WDT_CD_LAST) begin
            done_nxt = 1'b1;
            state_nxt = CNT_OFF;
          end else begin
            cd_nxt = cd_r + 9'h1;
          end
        end
      end
      default: begin
        state_nxt = CNT_OFF;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= CNT_OFF;
      cnt_r <= 32'h0;
      cd_r <= 9'h0;
      to_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cd_r <= cd_nxt;
      to_r <= to_nxt;
      done_r <= done_nxt;
    end
  end

  assign wif.timeout = to_r;
  assign wif.cd_done = done_r;
  assign wif.cd_active = (state_r == CNT_CD);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_cd_full_length: assert property (@(posedge aclk) disable iff (!aresetn)
    done_r |-> $past(state_r) == CNT_CD && $past(cd_r) == `WDT_CD_LAST && $past(wif.tick))
    else $error("reset countdown ended early");
  a_cd_abort: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == CNT_CD && wif.clear |=> state_r != CNT_CD && !done_r)
    else $error("restart did not stop reset countdown");
  a_clear_count: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == CNT_RUN && wif.run && wif.clear |=> cnt_r == 32'h0 && !to_r)
    else $error("restart did not clear count");

endmodule

// >>> watchdog_timer_control.sv
// watchdog control register, interrupt logic and axi4-lite slave
`timescale 1ns/1ps
`include "wdt_cfg.svh"

// Notes on behaviour
// - a timeout raises an interrupt request only while irq_enable is set.
// - irq_enable clears on power-on reset and survives every other reset.
// - with only reset enabled a timeout sets the flag and resets after 512 ticks unless cancelled.
// - with both enabled a timeout interrupts and resets 512 ticks later unless cancelled.
// - software can clear the timeout flag but never set it.
// - timeout_select picks the interrupt timeout period.
// - the reset follows the interrupt timeout by 512 divider ticks.
// - a select change restarts the count and also cancels a running countdown.
// - a new select value is taken only together with restart_count in the same write.
// - the power-on flag is set by power-on reset and written to either value by software.
// - restart_count clears the count and always reads as zero.
// - reset_enable lets the watchdog reset the device, is set by power-on reset and writable by software.
// - a timeout sets the timeout flag when either enable is set.
// - a watchdog reset sets reset_occurred_flag, power-on reset clears it.
module watchdog_timer_control import wdt_pkg::*; #(
  parameter word_t TIMEOUT_SEL0 = `WDT_TIMEOUT0,
  parameter word_t TIMEOUT_SEL1 = `WDT_TIMEOUT1,
  parameter word_t TIMEOUT_SEL2 = `WDT_TIMEOUT2,
  parameter word_t TIMEOUT_SEL3 = `WDT_TIMEOUT3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic sys_reset_n,
  output logic wdt_reset,
  output logic irq
);

  wdt_if wif ();

  // --------------------------------------------------------------------------
  // synchroniser and tick divider
  // --------------------------------------------------------------------------
  logic ext_s1_r, ext_s2_r;
  logic [7:0] div_r, div_nxt;
  logic tick_r, tick_nxt;

  always_comb begin
    tick_nxt = (div_r == `WDT_DIV_LAST);
    div_nxt = tick_nxt ? 8'h00 : div_r + 8'h01;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1_r <= 1'b1;
      ext_s2_r <= 1'b1;
      div_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      ext_s1_r <= sys_reset_n;
      ext_s2_r <= ext_s1_r;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite slave
  // --------------------------------------------------------------------------
  logic aw_held_r, aw_held_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic w_held_r, w_held_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic w_lane0_r, w_lane0_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic do_wr, rd_clr;
  logic [7:0] wr_off, rd_off;
  logic [7:0] ctrl_view;

  logic rst_en_r, rst_occ_r, to_flag_r, irq_en_r, por_r;
  logic [1:0] sel_r;
  logic [1:0] status_r, mask_r;

  assign ctrl_view = {por_r, irq_en_r, sel_r, to_flag_r, rst_occ_r, rst_en_r, 1'b0};

  always_comb begin
    aw_held_nxt = aw_held_r;
    aw_addr_nxt = aw_addr_r;
    w_held_nxt = w_held_r;
    w_data_nxt = w_data_r;
    w_lane0_nxt = w_lane0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    rd_clr = 1'b0;
    wr_off = aw_addr_r & `WDT_ADDR_MASK;
    rd_off = araddr & `WDT_ADDR_MASK;
    do_wr = aw_held_r && w_held_r && !bvalid_r;
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_wr) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wr_off == `WDT_OFF_CTRL || wr_off == `WDT_OFF_STATUS ||
                   wr_off == `WDT_OFF_MASK) ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
    end
    if (awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = wdata;
      w_lane0_nxt = wstrb[0];
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `WDT_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (rd_off)
        `WDT_OFF_CTRL: rdata_nxt = {24'h00_0000, ctrl_view};
        `WDT_OFF_STATUS: begin
          rdata_nxt = {30'h0000_0000, status_r};
          rd_clr = 1'b1;
        end
        `WDT_OFF_MASK: rdata_nxt = {30'h0000_0000, mask_r};
        default: rresp_nxt = `WDT_RESP_SLVERR;
      endcase
    end
    awready_nxt = !aw_held_nxt;
    wready_nxt = !w_held_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_lane0_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `WDT_RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `WDT_RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_held_r <= w_held_nxt;
      w_data_r <= w_data_nxt;
      w_lane0_r <= w_lane0_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // watchdog control, status and interrupt
  // --------------------------------------------------------------------------
  logic rst_en_nxt, rst_occ_nxt, to_flag_nxt, irq_en_nxt, por_nxt;
  logic [1:0] sel_nxt, status_nxt, mask_nxt, st_set;
  logic wdt_reset_r, wdt_reset_nxt;
  logic irq_r, irq_nxt;
  logic cd_go_r, cd_go_nxt;
  logic ctrl_wr, restart, soft_rst;

  always_comb begin
    soft_rst = !ext_s2_r || wdt_reset_r;
    ctrl_wr = do_wr && w_lane0_r && (wr_off == `WDT_OFF_CTRL);
    restart = ctrl_wr && w_data_r[`WDT_B_RESTART];
    rst_en_nxt = rst_en_r;
    rst_occ_nxt = rst_occ_r;
    to_flag_nxt = to_flag_r;
    irq_en_nxt = irq_en_r;
    por_nxt = por_r;
    sel_nxt = sel_r;
    mask_nxt = mask_r;
    if (ctrl_wr) begin
      rst_en_nxt = w_data_r[`WDT_B_RST_EN];
      rst_occ_nxt = w_data_r[`WDT_B_RST_OCC];
      irq_en_nxt = w_data_r[`WDT_B_IRQ_EN];
      por_nxt = w_data_r[`WDT_B_POR];
      if (!w_data_r[`WDT_B_TO_FLAG]) begin
        to_flag_nxt = 1'b0;
      end
      if (restart) begin
        sel_nxt = w_data_r[`WDT_B_SEL_HI:`WDT_B_SEL_LO];
      end
    end
    if (do_wr && w_lane0_r && (wr_off == `WDT_OFF_MASK)) begin
      mask_nxt = w_data_r[1:0];
    end
    if (wif.timeout && (rst_en_r || irq_en_r)) begin
      to_flag_nxt = 1'b1;
    end
    if (soft_rst) begin
      to_flag_nxt = 1'b0;
      sel_nxt = `WDT_RST_SEL;
    end
    if (wdt_reset_r) begin
      rst_occ_nxt = 1'b1;
    end
    cd_go_nxt = cd_go_r;
    if (wif.timeout && rst_en_r) begin
      cd_go_nxt = 1'b1;
    end
    if (restart || soft_rst || !to_flag_nxt || !rst_en_nxt) begin
      cd_go_nxt = 1'b0;
    end
    wdt_reset_nxt = wif.cd_done && rst_en_r;
    st_set = 2'h0;
    st_set[`WDT_ST_TIMEOUT] = wif.timeout && irq_en_r;
    st_set[`WDT_ST_WDRESET] = wdt_reset_r;
    status_nxt = (rd_clr ? 2'h0 : status_r) | st_set;
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_en_r <= 1'b1;
      rst_occ_r <= 1'b0;
      to_flag_r <= 1'b0;
      irq_en_r <= 1'b0;
      por_r <= 1'b1;
      sel_r <= `WDT_RST_SEL;
      mask_r <= `WDT_RST_MASK;
      status_r <= `WDT_RST_STATUS;
      wdt_reset_r <= 1'b0;
      irq_r <= 1'b0;
      cd_go_r <= 1'b0;
    end else begin
      rst_en_r <= rst_en_nxt;
      rst_occ_r <= rst_occ_nxt;
      to_flag_r <= to_flag_nxt;
      irq_en_r <= irq_en_nxt;
      por_r <= por_nxt;
      sel_r <= sel_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      wdt_reset_r <= wdt_reset_nxt;
      irq_r <= irq_nxt;
      cd_go_r <= cd_go_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // counter link
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (sel_r)
      2'h0: wif.limit = TIMEOUT_SEL0;
      2'h1: wif.limit = TIMEOUT_SEL1;
      2'h2: wif.limit = TIMEOUT_SEL2;
      2'h3: wif.limit = TIMEOUT_SEL3;
    endcase
  end

  assign wif.tick = tick_r;
  assign wif.clear = restart || soft_rst;
  assign wif.run = rst_en_r || irq_en_r;
  assign wif.cd_arm = cd_go_r;

  wdt_counter u_counter (
    .aclk(aclk),
    .aresetn(aresetn),
    .wif(wif)
  );

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign wdt_reset = wdt_reset_r;
  assign irq = irq_r;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_flag_hw_set: assert property ($rose(to_flag_r) |-> $past(wif.timeout))
    else $error("timeout flag set without timeout");
  a_irq_needs_enable: assert property (
    $rose(status_r[`WDT_ST_TIMEOUT]) |-> $past(wif.timeout && irq_en_r))
    else $error("interrupt event while disabled");
  a_irq_output: assert property (##1 irq_r == |(status_r & mask_r))
    else $error("irq does not follow masked status");
  a_sel_with_restart: assert property (
    sel_r != $past(sel_r) |-> $past(restart || soft_rst))
    else $error("select changed without restart");
  a_reset_from_cd: assert property ($rose(wdt_reset_r) |-> $past(wif.cd_done))
    else $error("watchdog reset without countdown");
  a_reset_sets_occ: assert property (wdt_reset_r |=> rst_occ_r && !to_flag_r)
    else $error("watchdog reset not recorded");
  a_soft_keeps_enables: assert property (
    soft_rst && !ctrl_wr |=> irq_en_r == $past(irq_en_r) && rst_en_r == $past(rst_en_r)
      && por_r == $past(por_r))
    else $error("soft reset changed enables");
  a_timeout_sets_flag: assert property (
    wif.timeout && (rst_en_r || irq_en_r) && !soft_rst |=> to_flag_r)
    else $error("timeout did not set flag");
  a_restart_reads_zero: assert property (
    arvalid && arready_r && rd_off == `WDT_OFF_CTRL |=> !rdata_r[`WDT_B_RESTART])
    else $error("restart bit read as one");

  c_timeout: cover property (wif.timeout && irq_en_r);
  c_wdt_reset: cover property (wdt_reset_r);
  c_restart_in_cd: cover property (wif.cd_active && restart);
  c_irq: cover property ($rose(irq_r));

endmodule

// >>> watchdog_timer_control_bench.sv
// self-checking bench for the watchdog control block
`timescale 1ns/1ps
`include "wdt_cfg.svh"
module watchdog_timer_control_bench import wdt_pkg::*;;
  logic aclk, aresetn, sys_reset_n;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wdt_reset, irq;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  int n_mismatch, n_compared, n_wdr, n_irq, n, w;

  watchdog_timer_control #(.TIMEOUT_SEL0(32'h4), .TIMEOUT_SEL1(32'h8),
    .TIMEOUT_SEL2(32'h10), .TIMEOUT_SEL3(32'h20)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sys_reset_n(sys_reset_n), .wdt_reset(wdt_reset), .irq(irq));

  // ---------------------------------------------------------------------------
  // clock, pulse counters, watchdog
  // ---------------------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (wdt_reset === 1'b1) n_wdr++;
    if (irq === 1'b1) n_irq++;
  end
  initial begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    test_done();
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi);
    chk({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask
  task automatic clk(input int k);
    repeat (k) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic wait_hi(input bit rst, input int lim);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!((rst ? wdt_reset : irq) === 1'b1) && n < lim);
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_power_on();
    rdr(`WDT_OFF_CTRL);
    chk(rd, 32'h82);
    rdr(`WDT_OFF_STATUS);
    chk(rd, 32'h0);
    rdr(`WDT_OFF_MASK);
    chk(rd, 32'h0);
    rdr(8'h10);
    chk(rs, `WDT_RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h0C, 8'hFF);
    chk(rs, `WDT_RESP_SLVERR);
    $display("test power_on done");
  endtask
  task automatic t_fields();
    wr(`WDT_OFF_CTRL, 8'h30);
    rdr(`WDT_OFF_CTRL);
    chk(rd, 32'h00);
    wr(`WDT_OFF_CTRL, 8'h08);
    rdr(`WDT_OFF_CTRL);
    chk(rd, 32'h0);
    wr(`WDT_OFF_CTRL, 8'h21);
    rdr(`WDT_OFF_CTRL);
    chk(rd, 32'h20);
    wr(`WDT_OFF_MASK, 8'h01);
    wr(`WDT_OFF_STATUS, 8'hFF);
    rdr(`WDT_OFF_MASK);
    chk(rd, 32'h1);
    $display("test fields done");
  endtask
  task automatic t_period();
    int lim;
    for (int s = 0; s < 4; s++) begin
      lim = 16 << s;
      wr(`WDT_OFF_CTRL, 8'h41 | 8'(s << 4));
      wait_hi(0, 400);
      rng(n, lim - 3, lim + 6);
      wr(`WDT_OFF_CTRL, 8'h08);
      rdr(`WDT_OFF_CTRL);
      chk(rd, 32'h08 | 32'(s << 4));
      rdr(`WDT_OFF_STATUS);
      chk(rd, 32'h1);
      rdr(`WDT_OFF_STATUS);
      chk(rd, 32'h0);
      clk(2);
      chk(irq, 1'b0);
      wr(`WDT_OFF_CTRL, 8'h00);
      rdr(`WDT_OFF_CTRL);
      chk(rd, 32'(s << 4));
    end
    $display("test period done");
  endtask
  task automatic t_soft();
    wr(`WDT_OFF_CTRL, 8'hD3);
    sys_reset_n <= 1'b0;
    clk(4);
    sys_reset_n <= 1'b1;
    clk(3);
    rdr(`WDT_OFF_CTRL);
    chk(rd, 32'hC2);
    wr(`WDT_OFF_CTRL, 8'h00);
    rdr(`WDT_OFF_STATUS);
    $display("test soft_reset done");
  endtask
  task automatic t_restart();
    w = n_wdr;
    repeat (10) begin
      wr(`WDT_OFF_CTRL, 8'h33);
      clk(60);
    end
    rdr(`WDT_OFF_CTRL);
    chk(rd, 32'h32);
    chk(n_wdr - w, 0);
    wr(`WDT_OFF_CTRL, 8'h01);
    $display("test restart done");
  endtask
  task automatic t_reset_only();
    w = n_irq;
    wr(`WDT_OFF_CTRL, 8'h03);
    wait_hi(1, 3000);
    rng(n, 2056, 2072);
    chk(n_irq - w, 0);
    clk(1);
    rdr(`WDT_OFF_CTRL);
    chk(rd, 32'h06);
    rdr(`WDT_OFF_STATUS);
    chk(rd, 32'h2);
    wr(`WDT_OFF_CTRL, 8'h00);
    rdr(`WDT_OFF_STATUS);
    $display("test reset_only done");
  endtask
  task automatic t_both();
    wr(`WDT_OFF_CTRL, 8'h43);
    wait_hi(0, 200);
    rdr(`WDT_OFF_CTRL);
    chk(rd & 32'hFB, 32'h4A);
    w = n_wdr;
    wait_hi(1, 3000);
    rng(n, 2034, 2052);
    clk(1);
    chk(n_wdr - w, 1);
    wr(`WDT_OFF_CTRL, 8'h00);
    rdr(`WDT_OFF_STATUS);
    chk(rd, 32'h3);
    $display("test both done");
  endtask
  task automatic t_cancel();
    wr(`WDT_OFF_MASK, 8'h00);
    wr(`WDT_OFF_CTRL, 8'h43);
    clk(40);
    chk(irq, 1'b0);
    wr(`WDT_OFF_CTRL, 8'h7B);
    w = n_wdr;
    clk(2120);
    chk(n_wdr - w, 0);
    wr(`WDT_OFF_CTRL, 8'h40);
    w = n_wdr;
    clk(2200);
    chk(n_wdr - w, 0);
    wr(`WDT_OFF_CTRL, 8'h41);
    rdr(`WDT_OFF_STATUS);
    chk(rd & 32'h1, 32'h1);
    wr(`WDT_OFF_MASK, 8'h01);
    clk(20);
    chk(irq, 1'b1);
    wr(`WDT_OFF_CTRL, 8'h00);
    rdr(`WDT_OFF_STATUS);
    clk(2);
    chk(irq, 1'b0);
    $display("test cancel done");
  endtask
  task automatic t_por_again();
    aresetn <= 1'b0;
    clk(2);
    aresetn <= 1'b1;
    clk(3);
    rdr(`WDT_OFF_CTRL);
    chk(rd, 32'h82);
    $display("test por_again done");
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    n_wdr = 0;
    n_irq = 0;
    aresetn = 1'b0;
    sys_reset_n = 1'b1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    clk(12);
    aresetn <= 1'b1;
    clk(3);
    t_power_on();
    t_fields();
    t_period();
    t_soft();
    t_restart();
    t_reset_only();
    t_both();
    t_cancel();
    t_por_again();
    test_done();
  end
endmodule
